// file: rtl/adc_sequencing_power_control.sv
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Sequential mode needs external clock and enable
// - Sequential finish: busy inactive one conversion clock
// - Results are sixteen-bit two's complement
// - Reset aborts, defaults control, samples all
// - Standby powers down all but interface
// - Ten milliseconds settle after standby release
// - Standby keeps control register, no reset needed
// - Per-pair power-down, ten milliseconds to resettle
// - Reference off only when all pairs down
// - Auto-sleep enters reduced power at busy fall
// - Start edge wakes; convert six clocks later
// - Auto-sleep cycle is 24.5 conversion clocks; code uses 24 (6 wake plus 18 conversion)
// - Reference stays on during auto-sleep
// - Power-down software only, immediate both ways
// - Polarity bit zero high busy, one low
module adc_sequencing_power_control
	import adc_ctrl_pkg::*;
#(
	parameter int SETTLE_CYCLES = SETTLE_CYCLES_DEF
) (
	input wire logic clock_in,
	input wire logic resetn_in,
	input wire logic [7:0] addr_in,
	input wire logic [31:0] wr_data_in,
	input wire logic wr_strobe_in,
	input wire logic rd_strobe_in,
	input wire logic [2:0] pair_conversion_start_in,
	input wire logic standby_n_in,
	input wire logic software_mode_select_in,
	input wire logic conv_clock_in,
	input wire logic [95:0] sar_code_in,
	output logic [31:0] rd_data_out,
	output logic busy_out,
	output logic irq_out,
	output logic [2:0] pair_power_on_out,
	output logic reference_on_out,
	output logic reduced_power_out,
	output logic ready_out
);
	localparam logic [SETTLE_CNT_W-1:0] SETTLE_LOAD = SETTLE_CNT_W'(SETTLE_CYCLES);
	localparam logic [SETTLE_CNT_W-1:0] CNT_ZERO = '0;
	localparam logic [SETTLE_CNT_W-1:0] CNT_ONE = SETTLE_CNT_W'(1);
	// Pins reset to their idle levels, so no false edge follows reset
	localparam logic [SYNC_W-1:0] PIN_IDLE = 6'h08;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	// Pin synchronisers
	logic [SYNC_W-1:0] meta_r, sync_r, prev_r;
	wire [SYNC_W-1:0] pins_w = {conv_clock_in, software_mode_select_in, standby_n_in,
		pair_conversion_start_in};

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			meta_r <= PIN_IDLE;
			sync_r <= PIN_IDLE;
			prev_r <= PIN_IDLE;
		end else begin
			meta_r <= pins_w;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	wire [2:0] start_rise_w = sync_r[2:0] & ~prev_r[2:0];
	wire standby_w = !sync_r[3];
	wire standby_release_w = sync_r[3] && !prev_r[3];
	wire sw_mode_w = sync_r[4];
	wire ext_rise_w = sync_r[5] && !prev_r[5];

	// Control register and derived modes
	logic [31:0] ctrl_r;
	logic [IRQ_W-1:0] irq_stat_r, irq_mask_r;
	wire [2:0] pd_bits_w = ctrl_r[BIT_PD_LSB+2:BIT_PD_LSB];
	wire [2:0] en_bits_w = ctrl_r[BIT_EN_LSB+2:BIT_EN_LSB];
	wire external_clock_select_w = ctrl_r[BIT_EXTERNAL_CLOCK_SELECT];
	wire busy_pol_w = ctrl_r[BIT_BUSY_POL];
	wire auto_sleep_w = ctrl_r[BIT_AUTO_SLEEP];
	wire seq_active_w = sw_mode_w && external_clock_select_w && ctrl_r[BIT_SEQ];
	wire [2:0] pd_eff_w = pd_bits_w & {3{sw_mode_w}};

	wire wr_ctrl_w = wr_strobe_in && hit(addr_in, OFS_CTRL);
	wire wr_irq_stat_w = wr_strobe_in && hit(addr_in, OFS_IRQ_STAT);
	wire wr_irq_mask_w = wr_strobe_in && hit(addr_in, OFS_IRQ_MASK);

	// Conversion clock: internal divider or external pin
	logic [3:0] div_r;
	wire int_tick_w = (div_r == INT_CCLK_LAST);
	wire cclk_tick_w = (sw_mode_w && external_clock_select_w) ? ext_rise_w : int_tick_w;

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			div_r <= 4'h0;
		end else begin
			div_r <= int_tick_w ? 4'h0 : div_r + 4'h1;
		end
	end

	// Settling counters: three pairs and standby
	logic [3:0] pd_q_r;
	wire [3:0] settle_load_w = {standby_w || standby_release_w, pd_eff_w | (pd_q_r[2:0] & ~pd_eff_w)};
	logic [SETTLE_CNT_W-1:0] settle_cnt_r [4];
	wire [3:0] settle_zero_w;
	wire [3:0] settle_done_w;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_settle
			always_ff @(posedge clock_in or negedge resetn_in) begin
				if (!resetn_in) begin
					settle_cnt_r[gi] <= CNT_ZERO;
				end else if (settle_load_w[gi]) begin
					settle_cnt_r[gi] <= SETTLE_LOAD;
				end else if (settle_cnt_r[gi] != CNT_ZERO) begin
					settle_cnt_r[gi] <= settle_cnt_r[gi] - CNT_ONE;
				end
			end
			assign settle_zero_w[gi] = (settle_cnt_r[gi] == CNT_ZERO);
			assign settle_done_w[gi] = (settle_cnt_r[gi] == CNT_ONE) && !settle_load_w[gi];
		end
	endgenerate

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			pd_q_r <= 4'h0;
		end else begin
			pd_q_r <= {1'b0, pd_eff_w};
		end
	end

	wire standby_n_ready_w = settle_zero_w[3] && !standby_w;
	wire [2:0] pair_ready_w = settle_zero_w[2:0] & ~pd_eff_w;

	// Channel pairs
	logic sleep_r;
	wire [2:0] pair_ok_w = en_bits_w & pair_ready_w & {3{standby_n_ready_w}};
	wire [2:0] start_ok_w = start_rise_w & pair_ok_w;
	wire [2:0] abort_w = pd_eff_w | {3{standby_w}};
	wire [2:0] pair_busy_w;
	wire [2:0] pair_done_w;
	wire [31:0] result_w [3];

	generate
		for (gi = 0; gi < PAIRS; gi++) begin : g_pair
			pair_converter u_pair (
				.clock_in(clock_in),
				.resetn_in(resetn_in),
				.tick_in(cclk_tick_w),
				.start_in(start_ok_w[gi]),
				.sleep_in(sleep_r),
				.abort_in(abort_w[gi]),
				.code_in(sar_code_in[32*gi+31:32*gi]),
				.busy_out(pair_busy_w[gi]),
				.done_out(pair_done_w[gi]),
				.result_out(result_w[gi])
			);
		end
	endgenerate

	// Busy, sequential gap and auto-sleep
	logic busy_q_r, gap_r;
	wire busy_raw_w = |pair_busy_w;
	wire busy_fall_w = busy_q_r && !busy_raw_w;
	wire gap_set_w = seq_active_w && (|pair_done_w) && busy_raw_w;
	wire gap_nxt = gap_set_w ? 1'b1 : (cclk_tick_w ? 1'b0 : gap_r);
	wire sleep_nxt = (|start_ok_w) ? 1'b0 :
		(!auto_sleep_w ? 1'b0 : (busy_fall_w ? 1'b1 : sleep_r));

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			busy_q_r <= 1'b0;
			gap_r <= 1'b0;
			sleep_r <= 1'b0;
		end else begin
			busy_q_r <= busy_raw_w;
			gap_r <= gap_nxt;
			sleep_r <= sleep_nxt;
		end
	end

	// Registers
	wire [IRQ_W-1:0] irq_event_w = {|settle_done_w[2:0], settle_done_w[3], pair_done_w};
	wire [IRQ_W-1:0] irq_stat_nxt = (irq_stat_r & ~(wr_irq_stat_w ? wr_data_in[IRQ_W-1:0] :
		IRQ_RESET)) | irq_event_w;
	wire [31:0] status_w = {19'h0_0000, sleep_r, reference_on_out, busy_raw_w, standby_n_ready_w,
		pair_power_on_out, pair_ready_w, pair_busy_w};
	wire [31:0] rd_mux_w = hit(addr_in, OFS_CTRL) ? ctrl_r :
		hit(addr_in, OFS_STATUS) ? status_w :
		hit(addr_in, OFS_IRQ_STAT) ? {27'h000_0000, irq_stat_r} :
		hit(addr_in, OFS_IRQ_MASK) ? {27'h000_0000, irq_mask_r} :
		hit(addr_in, OFS_RESULT0) ? result_w[0] :
		hit(addr_in, OFS_RESULT0 + OFS_STEP) ? result_w[1] :
		hit(addr_in, OFS_RESULT0 + OFS_STEP + OFS_STEP) ? result_w[2] : 32'h0000_0000;

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ctrl_r <= CTRL_RESET;
			irq_stat_r <= IRQ_RESET;
			irq_mask_r <= IRQ_RESET;
			rd_data_out <= 32'h0000_0000;
		end else begin
			// Standby leaves the control register to software alone
			if (wr_ctrl_w) begin
				ctrl_r <= wr_data_in & CTRL_WMASK;
			end
			if (wr_irq_mask_w) begin
				irq_mask_r <= wr_data_in[IRQ_W-1:0];
			end
			irq_stat_r <= irq_stat_nxt;
			rd_data_out <= rd_strobe_in ? rd_mux_w : 32'h0000_0000;
		end
	end

	// Registered pin outputs
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			busy_out <= 1'b0;
			irq_out <= 1'b0;
			pair_power_on_out <= 3'h0;
			reference_on_out <= 1'b0;
			reduced_power_out <= 1'b0;
			ready_out <= 1'b0;
		end else begin
			busy_out <= (busy_raw_w && !gap_nxt) ^ busy_pol_w;
			irq_out <= |(irq_stat_nxt & irq_mask_r);
			pair_power_on_out <= ~pd_eff_w & {3{!standby_w}};
			reference_on_out <= !standby_w && (pd_eff_w != 3'h7);
			reduced_power_out <= sleep_nxt;
			ready_out <= standby_n_ready_w;
		end
	end

	chk_seq_gate_only: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(busy_raw_w && !seq_active_w && !gap_r) |=> (busy_out != $past(busy_pol_w)))
		else $error("busy gap outside sequential mode");
	chk_gap_one_cclk: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(gap_r && cclk_tick_w && !gap_set_w) |=> !gap_r)
		else $error("busy gap longer than one conversion clock");
	chk_gap_busy_level: assert property (@(posedge clock_in) disable iff (!resetn_in)
		gap_set_w |=> (busy_out == $past(busy_pol_w)))
		else $error("busy not inactive during sequential gap");
	chk_result_format: assert property (@(posedge clock_in) disable iff (!resetn_in)
		pair_done_w[0] |-> result_w[0][15:0] == ($past(sar_code_in[15:0]) ^ SIGN_FLIP))
		else $error("result not two's complement");
	chk_standby_powers: assert property (@(posedge clock_in) disable iff (!resetn_in)
		standby_w |=> (pair_power_on_out == 3'h0 && !reference_on_out && !busy_raw_w))
		else $error("standby did not power down");
	chk_standby_ctrl: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(standby_w && !wr_ctrl_w) |=> $stable(ctrl_r))
		else $error("control register changed in standby");
	chk_settle_hold: assert property (@(posedge clock_in) disable iff (!resetn_in)
		standby_release_w |=> (!ready_out && !(|start_ok_w)) [*2])
		else $error("ready too early after standby");
	chk_pair_settle: assert property (@(posedge clock_in) disable iff (!resetn_in)
		$fell(pd_eff_w[0]) |-> !pair_ok_w[0] ##1 !pair_ok_w[0])
		else $error("pair usable before settling");
	chk_ref_all_down: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(pd_eff_w == 3'h7) |=> !reference_on_out)
		else $error("reference on with all pairs down");
	chk_ref_in_sleep: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(sleep_r && !standby_w && pd_eff_w != 3'h7) |=> reference_on_out)
		else $error("reference off during auto-sleep");
	chk_sleep_at_fall: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(auto_sleep_w && busy_fall_w && !(|start_ok_w)) |=> reduced_power_out && sleep_r)
		else $error("no sleep at busy fall");
	chk_wake_on_start: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(sleep_r && |start_ok_w) |=> !reduced_power_out && busy_raw_w)
		else $error("start edge did not wake");
	chk_pd_sw_only: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(!sw_mode_w && !standby_w) |=> pair_power_on_out == 3'h7)
		else $error("pair powered down in hardware mode");

	// Bus, interrupt and power checks
	chk_busy_idle_level: assert property (@(posedge clock_in) disable iff (!resetn_in)
		!busy_raw_w |=> (busy_out == $past(busy_pol_w)))
		else $error("busy not at idle level");
	chk_irq_level: assert property (@(posedge clock_in) disable iff (!resetn_in)
		irq_out == |(irq_stat_r & $past(irq_mask_r)))
		else $error("interrupt level wrong");
	chk_irq_sticky: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(irq_stat_r[0] && !(wr_irq_stat_w && wr_data_in[0])) |=> irq_stat_r[0])
		else $error("status bit lost without clear");
	chk_irq_set_wins: assert property (@(posedge clock_in) disable iff (!resetn_in)
		pair_done_w[0] |=> irq_stat_r[0])
		else $error("done event not recorded");
	chk_rd_idle_zero: assert property (@(posedge clock_in) disable iff (!resetn_in)
		!rd_strobe_in |=> (rd_data_out == 32'h0000_0000))
		else $error("read data outside read cycle");
	chk_rd_ctrl_value: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(rd_strobe_in && hit(addr_in, OFS_CTRL)) |=> (rd_data_out == $past(ctrl_r)))
		else $error("control read wrong");
	chk_ctrl_reserved: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(ctrl_r & ~CTRL_WMASK) == 32'h0000_0000)
		else $error("reserved control bit set");
	chk_sleep_off_clear: assert property (@(posedge clock_in) disable iff (!resetn_in)
		!auto_sleep_w |=> !reduced_power_out)
		else $error("sleep without auto-sleep enabled");
	chk_sleep_wake: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(|start_ok_w) |=> !sleep_r)
		else $error("start did not clear sleep");
	chk_conv_accept: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(start_ok_w[0] && !pair_busy_w[0]) |=> pair_busy_w[0])
		else $error("accepted start did not begin");
	chk_pd_immediate: assert property (@(posedge clock_in) disable iff (!resetn_in)
		pd_eff_w[0] |=> (!pair_power_on_out[0] && !pair_busy_w[0]))
		else $error("power-down not immediate");
	chk_pd_power_back: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(!pd_eff_w[0] && !standby_w) |=> pair_power_on_out[0])
		else $error("pair not powered after clear");
	chk_pd_not_ready: assert property (@(posedge clock_in) disable iff (!resetn_in)
		pd_eff_w[1] |=> !pair_ready_w[1])
		else $error("powered-down pair reported ready");
	chk_start_refused: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(start_rise_w[0] && !pair_ok_w[0] && !pair_busy_w[0]) |=> !pair_busy_w[0])
		else $error("refused start began a conversion");
	chk_ref_on_normal: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(!standby_w && pd_eff_w != 3'h7) |=> reference_on_out)
		else $error("reference off with a pair up");
	chk_standby_ready: assert property (@(posedge clock_in) disable iff (!resetn_in)
		standby_w |=> !ready_out)
		else $error("ready during standby");
	chk_settle_not_ready: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(settle_cnt_r[3] != CNT_ZERO) |=> !ready_out)
		else $error("ready while settle count runs");
	chk_settle_done_irq: assert property (@(posedge clock_in) disable iff (!resetn_in)
		settle_done_w[3] |=> irq_stat_r[IRQ_STANDBY_N_READY])
		else $error("settle end not recorded");
	chk_hw_mode_clock: assert property (@(posedge clock_in) disable iff (!resetn_in)
		!sw_mode_w |-> (cclk_tick_w == int_tick_w))
		else $error("external clock used in hardware mode");
endmodule
`default_nettype wire

// file: rtl/adc_ctrl_pkg.sv
package adc_ctrl_pkg;
	localparam int CLOCK_HZ = 125_000_000;
	localparam int SETTLE_TIME_MS = 10;
	localparam int SETTLE_CYCLES_DEF = SETTLE_TIME_MS * (CLOCK_HZ / 1000);
	localparam int SETTLE_CNT_W = 21;
	localparam int PAIRS = 3;
	localparam int SYNC_W = 6;
	localparam int WAKE_CCLK = 6;
	localparam int AUTO_SLEEP_HALF_CCLK = 49;
	localparam int CONV_CCLK = AUTO_SLEEP_HALF_CCLK / 2 - WAKE_CCLK;
	localparam logic [4:0] WAKE_LAST = 5'(WAKE_CCLK - 1);
	localparam logic [4:0] CONV_LAST = 5'(CONV_CCLK - 1);
	localparam logic [3:0] INT_CCLK_LAST = 4'h3;
	localparam logic [15:0] SIGN_FLIP = 16'h8000;
	localparam int BIT_EXTERNAL_CLOCK_SELECT = 11;
	localparam int BIT_PD_LSB = 13;
	localparam int BIT_BUSY_POL = 20;
	localparam int BIT_AUTO_SLEEP = 22;
	localparam int BIT_SEQ = 23;
	localparam int BIT_EN_LSB = 29;
	localparam logic [31:0] CTRL_RESET = 32'h0000_03FF;
	localparam logic [31:0] CTRL_WMASK = 32'hFFF7_EFFF;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
	localparam logic [7:0] OFS_RESULT0 = 8'h10;
	localparam logic [7:0] OFS_STEP = 8'h04;
	localparam int IRQ_W = 5;
	localparam int IRQ_STANDBY_N_READY = 3;
	localparam int IRQ_PAIR_READY = 4;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 5'h00;
	typedef enum logic [1:0] {PAIR_IDLE, PAIR_WAKE, PAIR_CONV} pair_state_t;
endpackage

// file: rtl/pair_converter.sv
`timescale 1ns/1ps
`default_nettype none
module pair_converter
	import adc_ctrl_pkg::*;
(
	input wire logic clock_in,
	input wire logic resetn_in,
	input wire logic tick_in,
	input wire logic start_in,
	input wire logic sleep_in,
	input wire logic abort_in,
	input wire logic [31:0] code_in,
	output logic busy_out,
	output logic done_out,
	output logic [31:0] result_out
);
	pair_state_t state_r, state_nxt;
	logic [4:0] cnt_r, cnt_nxt;
	logic done_r, done_nxt;
	logic [31:0] result_r;

	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		done_nxt = 1'b0;
		case (state_r)
			PAIR_IDLE: begin
				if (start_in) begin
					cnt_nxt = 5'h00;
					// Sleeping pair spends the wake delay acquiring first
					state_nxt = sleep_in ? PAIR_WAKE : PAIR_CONV;
				end
			end
			PAIR_WAKE: begin
				if (tick_in) begin
					if (cnt_r == WAKE_LAST) begin
						cnt_nxt = 5'h00;
						state_nxt = PAIR_CONV;
					end else begin
						cnt_nxt = cnt_r + 5'h01;
					end
				end
			end
			PAIR_CONV: begin
				if (tick_in) begin
					// Wake plus conversion fill the auto-sleep cycle
					if (cnt_r == CONV_LAST) begin
						state_nxt = PAIR_IDLE;
						done_nxt = 1'b1;
					end else begin
						cnt_nxt = cnt_r + 5'h01;
					end
				end
			end
			default: begin
				state_nxt = PAIR_IDLE;
			end
		endcase
		if (abort_in) begin
			state_nxt = PAIR_IDLE;
			cnt_nxt = 5'h00;
			done_nxt = 1'b0;
		end
	end

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_r <= PAIR_IDLE;
			cnt_r <= 5'h00;
			done_r <= 1'b0;
			result_r <= 32'h0000_0000;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			done_r <= done_nxt;
			if (done_nxt) begin
				// Offset code to two's complement
				result_r <= {code_in[31:16] ^ SIGN_FLIP, code_in[15:0] ^ SIGN_FLIP};
			end
		end
	end

	assign busy_out = (state_r != PAIR_IDLE);
	assign done_out = done_r;
	assign result_out = result_r;

	chk_wake_then_conv: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(state_r == PAIR_IDLE && start_in && sleep_in && !abort_in) |=> state_r == PAIR_WAKE)
		else $error("sleeping pair did not enter wake delay");
endmodule
`default_nettype wire

// file: test/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input wire logic clock_in,
	output logic conv_clock_out,
	output logic [2:0] start_out,
	output logic standby_n_out
);
	int half_cnt;
	initial begin
		conv_clock_out = 1'b0;
		start_out = 3'h0;
		standby_n_out = 1'b1;
		half_cnt = 0;
	end
	// Free-running conversion clock, five system clocks per phase
	always @(posedge clock_in) begin
		half_cnt <= (half_cnt == 4) ? 0 : half_cnt + 1;
		if (half_cnt == 4) begin
			conv_clock_out <= ~conv_clock_out;
		end
	end
	// Start pulse launched and dropped inside one high phase
	task automatic start_pair(input int idx);
		@(posedge clock_in);
		while (!(conv_clock_out && half_cnt == 0)) begin
			@(posedge clock_in);
		end
		start_out[idx] <= 1'b1;
		repeat (3) @(posedge clock_in);
		start_out[idx] <= 1'b0;
	endtask
	task automatic standby(input logic level_n);
		@(posedge clock_in);
		standby_n_out <= level_n;
	endtask
endmodule
`default_nettype wire

// file: test/adc_sequencing_power_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin fail_count++; \
$display("MISMATCH t=%0t got %h exp %h", $time, got, exp); end end
`define WAITV(cond, n) begin wcnt = 0; while (!(cond) && wcnt < (n)) begin \
@(posedge clock_in); #1; wcnt++; end if (!(cond)) begin fail_count++; results(); end end
module adc_sequencing_power_control_tb;
	import adc_ctrl_pkg::*;
	localparam int SETTLE = 20;
	logic clock_in, resetn_in, wr_strobe_in, rd_strobe_in, software_mode_select_in;
	logic [7:0] addr_in;
	logic [31:0] wr_data_in, rd_data_out, d;
	logic [95:0] sar_code_in;
	logic busy_out, irq_out, reference_on_out, reduced_power_out, ready_out;
	logic conv_clk, standby_n;
	logic [2:0] starts, pair_power_on_out;
	int fail_count, cmp_count, wcnt;
	host_model host (.clock_in(clock_in), .conv_clock_out(conv_clk), .start_out(starts),
		.standby_n_out(standby_n));
	adc_sequencing_power_control #(.SETTLE_CYCLES(SETTLE)) dut (
		.clock_in(clock_in), .resetn_in(resetn_in), .addr_in(addr_in),
		.wr_data_in(wr_data_in), .wr_strobe_in(wr_strobe_in), .rd_strobe_in(rd_strobe_in),
		.pair_conversion_start_in(starts), .standby_n_in(standby_n),
		.software_mode_select_in(software_mode_select_in), .conv_clock_in(conv_clk),
		.sar_code_in(sar_code_in), .rd_data_out(rd_data_out), .busy_out(busy_out),
		.irq_out(irq_out), .pair_power_on_out(pair_power_on_out),
		.reference_on_out(reference_on_out), .reduced_power_out(reduced_power_out),
		.ready_out(ready_out));
	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock_in);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clock_in);
		addr_in <= a;
		wr_data_in <= v;
		wr_strobe_in <= 1'b1;
		@(posedge clock_in);
		wr_strobe_in <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clock_in);
		addr_in <= a;
		rd_strobe_in <= 1'b1;
		@(posedge clock_in);
		rd_strobe_in <= 1'b0;
		#1 d = rd_data_out;
	endtask
	task automatic conv_once();
		`WAITV(busy_out, 12)
		`WAITV(!busy_out, 400)
	endtask
	task automatic t_defaults();
		rd(OFS_CTRL);
		`CHK(d, CTRL_RESET)
		rd(8'h40);
		`CHK(d, 32'h0000_0000)
		`CHK(busy_out, 1'b0)
	endtask
	task automatic t_convert();
		wr(OFS_CTRL, 32'hE000_03FF);
		wr(OFS_IRQ_MASK, 32'h0000_0003);
		host.start_pair(0);
		tick(8); // Spacing covers one pair readout
		host.start_pair(1);
		tick(8);
		host.start_pair(2);
		conv_once();
		rd(OFS_RESULT0 + OFS_STEP + OFS_STEP);
		`CHK(d, 32'h0001_FFFE)
		rd(OFS_RESULT0);
		`CHK(d, 32'h8000_7FFF)
		rd(OFS_RESULT0 + OFS_STEP);
		`CHK(d, 32'hFFFF_0000)
		`CHK(irq_out, 1'b1)
		rd(OFS_IRQ_STAT);
		`CHK(d[2:0], 3'b111)
		wr(OFS_IRQ_STAT, 32'h0000_0007);
		tick(2);
		`CHK(irq_out, 1'b0)
	endtask
	task automatic t_polarity();
		wr(OFS_CTRL, 32'h2010_03FF);
		tick(3);
		`CHK(busy_out, 1'b1)
		host.start_pair(0);
		`WAITV(!busy_out, 12)
		`WAITV(busy_out, 400)
	endtask
	task automatic t_sleep();
		wr(OFS_CTRL, 32'h2040_03FF);
		host.start_pair(0);
		conv_once();
		tick(2);
		`CHK(reduced_power_out, 1'b1)
		`CHK(reference_on_out, 1'b1)
		host.start_pair(0);
		`WAITV(busy_out, 12)
		`CHK(reduced_power_out, 1'b0)
		`WAITV(!busy_out, 400)
		`CHK(wcnt >= 90 && wcnt <= 100, 1'b1)
		wr(OFS_CTRL, 32'h2000_03FF);
	endtask
	task automatic t_power_down();
		@(posedge clock_in);
		software_mode_select_in <= 1'b0;
		wr(OFS_CTRL, 32'h0000_03FF); // Enable dropped first
		wr(OFS_CTRL, 32'h0000_23FF);
		tick(4);
		`CHK(pair_power_on_out, 3'b111)
		@(posedge clock_in);
		software_mode_select_in <= 1'b1;
		tick(5);
		`CHK(pair_power_on_out, 3'b110)
		`CHK(reference_on_out, 1'b1)
		wr(OFS_CTRL, 32'h0000_E3FF);
		tick(2);
		`CHK(pair_power_on_out, 3'b000)
		`CHK(reference_on_out, 1'b0)
		wr(OFS_CTRL, 32'h2000_03FF);
		tick(2);
		`CHK(pair_power_on_out, 3'b111)
		rd(OFS_STATUS);
		`CHK(d[3], 1'b0)
		tick(SETTLE + 4); // Host waits out settling
		rd(OFS_STATUS);
		`CHK(d[5:3], 3'b111)
	endtask
	task automatic t_standby();
		host.standby(1'b0);
		tick(5);
		`CHK(ready_out, 1'b0)
		`CHK(pair_power_on_out, 3'b000)
		rd(OFS_CTRL);
		`CHK(d, 32'h2000_03FF)
		host.standby(1'b1);
		`WAITV(ready_out, 60) // Host waits for ready
		`CHK(wcnt >= SETTLE && wcnt <= SETTLE + 6, 1'b1)
		@(posedge clock_in);
		sar_code_in[31:0] <= 32'h1234_ABCD;
		host.start_pair(0);
		conv_once();
		rd(OFS_RESULT0);
		`CHK(d, 32'h9234_2BCD)
	endtask
	task automatic t_sequential();
		wr(OFS_CTRL, 32'h6080_0BFF);
		host.start_pair(0);
		tick(40);
		host.start_pair(1);
		`WAITV(!busy_out, 400)
		`WAITV(busy_out, 20)
		`CHK(wcnt >= 8 && wcnt <= 11, 1'b1)
		`WAITV(!busy_out, 400)
		wr(OFS_CTRL, 32'h2000_03FF);
	endtask
	task automatic t_reset();
		host.start_pair(0);
		`WAITV(busy_out, 12)
		@(posedge clock_in);
		resetn_in <= 1'b0;
		tick(1);
		`CHK(busy_out, 1'b0)
		@(posedge clock_in);
		resetn_in <= 1'b1;
		tick(4);
		rd(OFS_CTRL);
		`CHK(d, CTRL_RESET)
	endtask
	initial begin
		clock_in = 1'b0;
		forever #4 clock_in = ~clock_in;
	end
	initial begin
		resetn_in = 1'b0;
		addr_in = 8'h00;
		wr_data_in = 32'h0000_0000;
		wr_strobe_in = 1'b0;
		rd_strobe_in = 1'b0;
		software_mode_select_in = 1'b1;
		sar_code_in = {32'h8001_7FFE, 32'h7FFF_8000, 32'h0000_FFFF};
		fail_count = 0;
		cmp_count = 0;
		repeat (6) @(posedge clock_in);
		resetn_in <= 1'b1;
		tick(4);
		t_defaults();
		t_convert();
		t_polarity();
		t_sleep();
		t_power_down();
		t_standby();
		t_sequential();
		t_reset();
		results();
	end
endmodule
`default_nettype wire
